// file: rtl/pscp_device.sv
// Synthesiser serial control port, power-down and shared output pin logic
`timescale 1ns/1ps
`include "pscp_cfg.svh"
module pscp_device import pscp_pkg::*; #(
	parameter int POR_CYCLES = `PSCP_POR_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Serial link
	pscp_if.dev link,
	// Chip pins and internal signals
	input wire logic chip_enable_pin_i,
	input wire logic [31:0] gpo_sources_i,
	input wire logic freq_select_i,
	// Power and modulator
	output logic por_busy_o,
	output logic power_down_o,
	output logic [5:0] keep_on_o,
	output logic [23:0] phase_accumulator_o,
	output logic [23:0] start_seed_o
);
	typedef struct packed {
		logic [31:0] shift;
		logic [31:0] out_shift;
		logic [4:0] rd_addr;
		logic [23:0] enable_reg;
		logic [23:0] drv_reg;
		logic [23:0] gpo_reg;
		logic [23:0] seed;
		logic [23:0] accum;
		logic addressed;
		logic in_read;
		logic [23:0] por_cnt;
		logic por_busy;
		logic gpo_bit;
	} dev_state_t;
	dev_state_t s_q, s_d;
	// Synchronised link and pin levels
	logic sck_rise; // Serial clock rise after two flops
	logic sdi_s; // Serial data, same latency as the clock
	logic stb_rise; // Frame strobe rise
	logic cen_s; // Chip-enable pin level
	// Readback selection and shared pin controls
	logic [4:0] rd_sel;
	logic [23:0] rd_word;
	logic pin_read_sel;
	logic pin_drive;
	pscp_frame_t fr;

	// Serial clock synchroniser, only its rising edge is used
	pscp_sync u_sck (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(link.sck),
		.level_o(),
		.rise_o(sck_rise),
		.fall_o()
	);
	// Serial data synchroniser, matched to the clock path
	pscp_sync u_sdi (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(link.serial_data_input),
		.level_o(sdi_s),
		.rise_o(),
		.fall_o()
	);
	// Frame strobe synchroniser, commit on its rise
	pscp_sync u_stb (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(link.strobe),
		.level_o(),
		.rise_o(stb_rise),
		.fall_o()
	);
	// Chip-enable pin synchroniser
	pscp_sync u_cen (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.async_i(chip_enable_pin_i),
		.level_o(cen_s),
		.rise_o(),
		.fall_o()
	);

	// Received frame split into its fields
	assign fr = pscp_frame_t'(s_q.shift);

	// Read address in force once this strobe lands, so a reg-0 frame picks the next frame's data
	always_comb begin
		rd_sel = s_q.rd_addr;
		if (stb_rise && fr.chip == 3'h0 && fr.addr == `PSCP_REG_ID) begin
			if (fr.data[`PSCP_B_SOFT_RST]) begin
				rd_sel = 5'h00;
			end else begin
				rd_sel = fr.data[4:0];
			end
		end
	end

	// Readback mux over the register map
	always_comb begin
		case (rd_sel)
			`PSCP_REG_ID: rd_word = `PSCP_ID_VALUE;
			`PSCP_REG_ENABLE: rd_word = s_q.enable_reg;
			`PSCP_REG_DRV: rd_word = s_q.drv_reg;
			`PSCP_REG_GPO: rd_word = s_q.gpo_reg;
			`PSCP_REG_SEED: rd_word = s_q.seed;
			default: rd_word = 24'h00_0000;
		endcase
	end

	// Next state
	always_comb begin
		s_d = s_q;
		s_d.gpo_bit = gpo_sources_i[s_q.gpo_reg[4:0]];
		if (s_q.por_busy) begin
			// Registers held at defaults until the power-on delay ends
			if (s_q.por_cnt == 24'(POR_CYCLES - 1)) begin
				s_d.por_busy = 1'b0;
			end else begin
				s_d.por_cnt = s_q.por_cnt + 24'h00_0001;
			end
		end else begin
			// Serial port runs regardless of power-down
			if (sck_rise) begin
				s_d.shift = {s_q.shift[30:0], sdi_s};
				// First rise presents bit 31, each later rise the next bit
				if (s_q.in_read) begin
					s_d.out_shift = {s_q.out_shift[30:0], 1'b0};
				end
				s_d.in_read = 1'b1;
			end
			if (stb_rise) begin
				s_d.in_read = 1'b0;
				s_d.addressed = (fr.chip == 3'h0);
				if (fr.chip == 3'h0) begin
					case (fr.addr)
						`PSCP_REG_ID: begin
							s_d.rd_addr = fr.data[4:0];
							if (fr.data[`PSCP_B_SOFT_RST]) begin
								s_d.enable_reg = `PSCP_ENABLE_RST;
								s_d.drv_reg = `PSCP_DRV_RST;
								s_d.gpo_reg = `PSCP_GPO_RST;
								s_d.seed = `PSCP_SEED_RST;
								s_d.rd_addr = 5'h00;
							end
						end
						`PSCP_REG_ENABLE: s_d.enable_reg = fr.data;
						`PSCP_REG_DRV: s_d.drv_reg = fr.data;
						`PSCP_REG_GPO: s_d.gpo_reg = fr.data;
						`PSCP_REG_SEED: s_d.seed = fr.data;
						default: s_d.seed = s_q.seed;
					endcase
				end
				// Load readback word for the next frame, MSB first
				s_d.out_shift = {rd_word, 8'h00};
			end
			if (freq_select_i) begin
				s_d.accum = s_q.seed;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.enable_reg <= `PSCP_ENABLE_RST;
			s_q.drv_reg <= `PSCP_DRV_RST;
			s_q.gpo_reg <= `PSCP_GPO_RST;
			s_q.seed <= `PSCP_SEED_RST;
			s_q.por_busy <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Power-down decision and keep-on overrides
	always_comb begin
		if (s_q.enable_reg[`PSCP_B_PIN_SEL]) begin
			power_down_o = ~cen_s;
		end else begin
			power_down_o = ~s_q.enable_reg[`PSCP_B_SW_EN];
		end
	end
	assign keep_on_o = s_q.enable_reg[7:2];
	assign por_busy_o = s_q.por_busy;
	assign phase_accumulator_o = s_q.accum;
	assign start_seed_o = s_q.seed;

	// Shared pin: read data unless automux is prevented, drive when addressed or kept on
	always_comb begin
		pin_read_sel = s_q.in_read && !s_q.gpo_reg[`PSCP_B_NO_AUTOMUX];
		pin_drive = (s_q.addressed && s_q.in_read) || s_q.gpo_reg[`PSCP_B_KEEP_DRV];
	end
	// Driver-enable bit overrides all, pin stays off during power-on delay
	assign link.sdo_o = pin_read_sel ? s_q.out_shift[31] : s_q.gpo_bit;
	assign link.sdo_oe = s_q.drv_reg[`PSCP_B_DRV_EN] && !s_q.por_busy && pin_drive;
	// Pull sections disabled straight from the output-control bits
	assign link.sdo_pu_dis = s_q.gpo_reg[`PSCP_B_NO_PULLUP];
	assign link.sdo_pd_dis = s_q.gpo_reg[`PSCP_B_NO_PULLDN];
endmodule : pscp_device

// file: include/pscp_cfg.svh
// Constants for the serial control port, its frame layout and register map
`ifndef PSCP_CFG_SVH
`define PSCP_CFG_SVH
`define PSCP_FRAME_BITS 32
`define PSCP_DATA_BITS 24
`define PSCP_CNT_W 6
`define PSCP_REG_ID 5'h00
`define PSCP_REG_ENABLE 5'h01
`define PSCP_REG_DRV 5'h08
`define PSCP_REG_GPO 5'h0f
`define PSCP_REG_SEED 5'h1a
`define PSCP_ID_VALUE 24'h00_5a5a
`define PSCP_ENABLE_RST 24'h00_0003
`define PSCP_DRV_RST 24'h00_0020
`define PSCP_GPO_RST 24'h00_0001
`define PSCP_SEED_RST 24'h00_0000
`define PSCP_B_SOFT_RST 5
`define PSCP_B_PIN_SEL 0
`define PSCP_B_SW_EN 1
`define PSCP_B_DRV_EN 5
`define PSCP_B_NO_AUTOMUX 6
`define PSCP_B_KEEP_DRV 7
`define PSCP_B_NO_PULLUP 8
`define PSCP_B_NO_PULLDN 9
`define PSCP_POR_US 250
`define PSCP_CLK_MHZ 50
`define PSCP_POR_CYCLES (`PSCP_POR_US * `PSCP_CLK_MHZ)
`define PSCP_CMD_WRITE 2'h1
`define PSCP_CMD_READ 2'h2
`define PSCP_SCK_HALF 8'h04
`define PSCP_HREG_FRAME 5'h00
`define PSCP_HREG_STATUS 5'h01
`define PSCP_HREG_RX 5'h02
`endif

// file: include/pscp_pkg.sv
// Types shared by both ends of the serial control port
package pscp_pkg;
	typedef enum logic [2:0] {
		HST_IDLE = 3'b001,
		HST_SHIFT = 3'b010,
		HST_STROBE = 3'b100
	} pscp_hst_state_t;
	typedef struct packed {
		logic [23:0] data;
		logic [4:0] addr;
		logic [2:0] chip;
	} pscp_frame_t;
endpackage : pscp_pkg

// file: include/pscp_if.sv
// Serial link between host and synthesiser control port
`timescale 1ns/1ps
interface pscp_if;
	logic sck;
	logic serial_data_input;
	logic strobe;
	logic sdo_o;
	logic sdo_oe;
	logic sdo_pu_dis;
	logic sdo_pd_dis;
	modport host (output sck, output serial_data_input, output strobe, input sdo_o, input sdo_oe);
	modport dev (input sck, input serial_data_input, input strobe, output sdo_o, output sdo_oe, output sdo_pu_dis,
		output sdo_pd_dis);
endinterface : pscp_if

// file: rtl/pscp_sync.sv
// Two-flop synchroniser with edge detection after the second stage
`timescale 1ns/1ps
module pscp_sync (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Asynchronous level in, clean level and edges out
	input wire logic async_i,
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	logic [2:0] sh_q;
	// Stage one feeds only stage two
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sh_q <= 3'h0;
		end else begin
			sh_q <= {sh_q[1:0], async_i};
		end
	end
	assign level_o = sh_q[1];
	assign rise_o = sh_q[1] & ~sh_q[2];
	assign fall_o = ~sh_q[1] & sh_q[2];
endmodule : pscp_sync

// file: rtl/pscp_host.sv
// Host serial master: sends 32-bit frames and collects readback
`timescale 1ns/1ps
`include "pscp_cfg.svh"
module pscp_host import pscp_pkg::*; (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Serial link
	pscp_if.host link,
	// Software port
	input wire logic [4:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o
);
	typedef struct packed {
		pscp_hst_state_t st;
		logic [31:0] frame;
		logic [31:0] rx;
		logic [5:0] bit_cnt;
		logic [7:0] div;
		logic sck;
		logic strobe;
		logic [31:0] rdata;
		logic [31:0] last_rx;
	} hst_state_t;
	hst_state_t s_q, s_d;
	logic sdo_pin;
	logic sdo_s;

	// Released pin floats high through the board pull-up
	assign sdo_pin = link.sdo_oe ? link.sdo_o : 1'b1;
	pscp_sync u_sdo (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .async_i(sdo_pin), .level_o(sdo_s),
		.rise_o(), .fall_o());

	// Register 0 frame word, 1 status, 2 last readback
	always_comb begin
		s_d = s_q;
		s_d.rdata = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				`PSCP_HREG_FRAME: s_d.rdata = s_q.frame;
				`PSCP_HREG_STATUS: s_d.rdata = {31'h0000_0000, s_q.st != HST_IDLE};
				`PSCP_HREG_RX: s_d.rdata = s_q.last_rx;
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		case (s_q.st)
			HST_IDLE: begin
				if (wr_i && addr_i == `PSCP_HREG_FRAME) begin
					s_d.frame = wdata_i; // (software supplies chip and data)
					s_d.bit_cnt = 6'h00;
					s_d.div = 8'h00;
					s_d.st = HST_SHIFT;
				end
			end
			HST_SHIFT: begin
				s_d.div = s_q.div + 8'h01;
				if (s_q.div == `PSCP_SCK_HALF - 8'h01) begin
					s_d.div = 8'h00;
					s_d.sck = ~s_q.sck;
					if (s_q.sck) begin
						// Falling edge: present next bit, MSB first
						s_d.frame = {s_q.frame[30:0], 1'b0};
						if (s_q.bit_cnt == 6'(`PSCP_FRAME_BITS)) begin
							s_d.sck = 1'b0;
							s_d.st = HST_STROBE;
						end
					end else begin
						// Rising edge: take the bit the device placed one rise earlier
						s_d.rx = {s_q.rx[30:0], sdo_s};
						s_d.bit_cnt = s_q.bit_cnt + 6'h01;
						if (s_q.bit_cnt == 6'(`PSCP_FRAME_BITS - 1)) begin
							s_d.frame = s_q.frame;
						end
					end
				end
			end
			HST_STROBE: begin
				s_d.div = s_q.div + 8'h01;
				s_d.strobe = (s_q.div < `PSCP_SCK_HALF);
				// Bit placed by the 32nd rise has settled, before the strobe reloads the device
				if (s_q.div == `PSCP_SCK_HALF - 8'h02) begin
					s_d.rx = {s_q.rx[30:0], sdo_s};
				end
				if (s_q.div == `PSCP_SCK_HALF + `PSCP_SCK_HALF) begin
					s_d.strobe = 1'b0;
					s_d.last_rx = s_q.rx;
					s_d.st = HST_IDLE;
				end
			end
			default: s_d.st = HST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_q <= '0;
			s_q.st <= HST_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.sck = s_q.sck;
	assign link.serial_data_input = s_q.frame[31];
	assign link.strobe = s_q.strobe;
	assign rdata_o = s_q.rdata;
endmodule : pscp_host

// file: tb/pscp_link_sva.sv
// Protocol checks on the serial link between host and device
`timescale 1ns/1ps
module pscp_link_sva (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Link signals
	input wire logic sck,
	input wire logic serial_data_input,
	input wire logic strobe,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire logic sdo_pu_dis,
	input wire logic sdo_pd_dis
);
	logic [5:0] rises_q;
	default clocking dck @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);
	// Count serial clock rises since the last strobe
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			rises_q <= 6'h00;
		else if ($fell(strobe))
			rises_q <= 6'h00;
		else if ($rose(sck))
			rises_q <= rises_q + 6'h01;
	end
	a_sck_high: assert property ($rose(sck) |-> sck [*4] ##1 !sck) else $error("clock high phase wrong");
	a_sck_low: assert property ($fell(sck) |-> !sck [*4]) else $error("clock low phase too short");
	a_sdi_hold: assert property (sck && $past(sck) |-> $stable(serial_data_input)) else $error("data moved while clock high");
	a_strobe_len: assert property ($rose(strobe) |-> strobe [*4] ##1 !strobe) else $error("strobe length wrong");
	a_strobe_count: assert property ($rose(strobe) |-> rises_q == 6'h20) else $error("strobe not after 32 rises");
	a_strobe_quiet: assert property (strobe |-> !sck) else $error("clock high during strobe");
	a_reset_tristate: assert property ($fell(rst_i) |-> !sdo_oe [*8]) else $error("pin driven after reset");
	a_pull_steady: assert property ($changed({sdo_pu_dis, sdo_pd_dis}) |-> !sck) else $error("pull control moved");
endmodule : pscp_link_sva

// file: tb/pll_serial_control_port_test.sv
// Bench joining host and device ends of the serial control port
`timescale 1ns/1ps
`include "pscp_cfg.svh"
module pll_serial_control_port_test;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] addr_i = 5'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic chip_enable_pin_i = 1'b1;
	logic [31:0] gpo_sources_i = 32'h0000_0000;
	logic freq_select_i = 1'b0;
	logic por_busy_o;
	logic power_down_o;
	logic [5:0] keep_on_o;
	logic [23:0] phase_accumulator_o;
	logic [23:0] start_seed_o;
	logic [31:0] got;
	int errors = 0;
	int checks_done = 0;
	pscp_if link_if ();
	// Both ends and the link checker
	pscp_host pscp_host_inst (.ref_clk_i, .rst_i, .link(link_if.host), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
	pscp_device #(.POR_CYCLES(20)) pscp_device_inst (.ref_clk_i, .rst_i, .link(link_if.dev), .chip_enable_pin_i,
		.gpo_sources_i, .freq_select_i, .por_busy_o, .power_down_o, .keep_on_o, .phase_accumulator_o, .start_seed_o);
	pscp_link_sva pscp_link_sva_inst (.ref_clk_i, .rst_i, .sck(link_if.sck), .serial_data_input(link_if.serial_data_input), .strobe(link_if.strobe),
		.sdo_o(link_if.sdo_o), .sdo_oe(link_if.sdo_oe), .sdo_pu_dis(link_if.sdo_pu_dis), .sdo_pd_dis(link_if.sdo_pd_dis));
	// 50 MHz clock
	always #10 ref_clk_i = ~ref_clk_i;
	// Compare and count
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp_v);
		checks_done++;
		if (seen !== exp_v) begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp_v, seen);
		end
	endtask : check
	// Let cycles pass, end settled at falling edge
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
	endtask : wait_cyc
	// Software port write
	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : bus_wr
	// Software port read, data in following cycle
	task automatic bus_rd(input logic [4:0] a, output logic [31:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		@(negedge ref_clk_i);
		v = rdata_o;
	endtask : bus_rd
	// Send one frame and wait until the host is idle
	task automatic send(input logic [23:0] d, input logic [4:0] r, input logic [2:0] c);
		logic [31:0] st;
		bus_wr(`PSCP_HREG_FRAME, {d, r, c});
		st = 32'h0000_0001;
		for (int n = 0; n < 400 && st[0] !== 1'b0; n++)
			bus_rd(`PSCP_HREG_STATUS, st);
		check("host busy", 32'(st[0]), 32'h0000_0000);
		wait_cyc(6);
	endtask : send
	// Two-frame readback of one register
	task automatic read_reg(input logic [4:0] r);
		send({19'h0_0000, r}, `PSCP_REG_ID, 3'h0);
		send({19'h0_0000, r}, `PSCP_REG_ID, 3'h0);
		bus_rd(`PSCP_HREG_RX, got);
	endtask : read_reg
	// Counts and verdict
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run
	// Main sequence
	initial begin
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		wait_cyc(1);
		check("oe after reset", 32'(link_if.sdo_oe), 32'h0000_0000);
		check("por busy", 32'(por_busy_o), 32'h0000_0001);
		wait_cyc(24);
		check("por done", 32'(por_busy_o), 32'h0000_0000);
		read_reg(`PSCP_REG_ID);
		check("identifier", got, {`PSCP_ID_VALUE, 8'h00});
		check("oe after read", 32'(link_if.sdo_oe), 32'h0000_0000);
		send(24'h12_3456, `PSCP_REG_SEED, 3'h0);
		check("seed", 32'(start_seed_o), 32'h0012_3456);
		@(posedge ref_clk_i);
		freq_select_i <= 1'b1;
		@(posedge ref_clk_i);
		freq_select_i <= 1'b0;
		wait_cyc(1);
		check("start phase", 32'(phase_accumulator_o), 32'h0012_3456);
		send(24'h65_4321, `PSCP_REG_SEED, 3'h5);
		check("seed kept", 32'(start_seed_o), 32'h0012_3456);
		@(posedge ref_clk_i);
		chip_enable_pin_i <= 1'b0;
		wait_cyc(6);
		check("pin power down", 32'(power_down_o), 32'h0000_0001);
		send(24'h00_00fe, `PSCP_REG_ENABLE, 3'h0);
		check("soft enable", 32'(power_down_o), 32'h0000_0000);
		check("keep on", 32'(keep_on_o), 32'h0000_003f);
		send(24'h00_0000, `PSCP_REG_ENABLE, 3'h0);
		check("soft down", 32'(power_down_o), 32'h0000_0001);
		read_reg(`PSCP_REG_SEED);
		check("seed readback", got, 32'h1234_5600);
		@(posedge ref_clk_i);
		gpo_sources_i <= 32'h0000_0002;
		send(24'h00_03c1, `PSCP_REG_GPO, 3'h0);
		check("pull-up off", 32'(link_if.sdo_pu_dis), 32'h0000_0001);
		check("pull-down off", 32'(link_if.sdo_pd_dis), 32'h0000_0001);
		check("driver kept", 32'(link_if.sdo_oe), 32'h0000_0001);
		check("selected high", 32'(link_if.sdo_o), 32'h0000_0001);
		read_reg(`PSCP_REG_SEED);
		check("forced signal", got, 32'hffff_ffff);
		@(posedge ref_clk_i);
		gpo_sources_i <= 32'h0000_0000;
		wait_cyc(6);
		check("selected low", 32'(link_if.sdo_o), 32'h0000_0000);
		send(24'h00_0000, `PSCP_REG_DRV, 3'h0);
		check("driver off", 32'(link_if.sdo_oe), 32'h0000_0000);
		send(24'h00_0020, `PSCP_REG_ID, 3'h0);
		check("seed after soft reset", 32'(start_seed_o), 32'(`PSCP_SEED_RST));
		check("pull-up after soft reset", 32'(link_if.sdo_pu_dis), 32'h0000_0000);
		complete_run();
	end
	// Cut a hung run short
	initial begin
		repeat (40000) @(posedge ref_clk_i);
		errors++;
		complete_run();
	end
endmodule : pll_serial_control_port_test
